// >>> logic/serial_regs.svh
// constants for the dual serial port block
// assumes sys_clk at 250 MHz and 16x oversampling
`ifndef SERIAL_REGS_SVH
`define SERIAL_REGS_SVH
`define ADDR_PORT_A 8'h09
`define ADDR_PORT_B 8'h0a
`define ADDR_DISPLAY 8'h01
`define CFG_W 13
`define CFG_BAUD_LSB 0
`define CFG_PAR_LSB 3
`define CFG_DATA8 6
`define CFG_STOP2 7
`define CFG_RXPACE 8
`define CFG_TXPACE 9
`define CFG_RXECHO 10
`define CFG_SERIN 11
`define CFG_PROGECHO 12
`define CFG_DEFAULT 13'h1b46
`define CHAR_XON 8'h11
`define CHAR_XOFF 8'h13
`define OVERSAMPLE 16
`define CLK_HZ 250000000
`define BAUD_0 150
`define BAUD_1 300
`define BAUD_2 600
`define BAUD_3 1200
`define BAUD_4 2400
`define BAUD_5 4800
`define BAUD_6 9600
`define BAUD_7 19200
`define RX_DEPTH 2000
`define RX_STOP_MARGIN 64
`endif

// >>> logic/serial_pkg.sv
// types shared by the serial port files
// assumes serial_regs.svh holds the numbers
package serial_pkg;
  typedef enum logic [2:0] {
    PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2, PAR_ONE = 3'h3, PAR_ZERO = 3'h4
  } parity_t;
  typedef enum logic [3:0] {
    RS_IDLE = 4'h1, RS_START = 4'h2, RS_BITS = 4'h4, RS_STOP = 4'h8
  } rx_state_t;
  typedef enum logic [1:0] {TS_IDLE = 2'h1, TS_SEND = 2'h2} tx_state_t;
  typedef enum logic [3:0] {
    PC_OPEN = 4'h1, PC_SEND_OFF = 4'h2, PC_STOPPED = 4'h4, PC_SEND_ON = 4'h8
  } pace_state_t;
endpackage

// >>> logic/serial_chan.sv
// one three-wire async port: framer, deframer, receive buffer
// assumes rxd_pin is asynchronous and all else is on sys_clk
`timescale 1ns/1ps
`include "serial_regs.svh"
module serial_chan #(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int RX_DEPTH = `RX_DEPTH,
  parameter int LW = $clog2(RX_DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] baud_sel,
  input serial_pkg::parity_t parity,
  input wire logic data8,
  input wire logic stop2,
  input wire logic tx_pace,
  input wire logic rxd_pin,
  output logic txd,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_force,
  output logic tx_ready,
  output logic tx_held,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic [LW-1:0] rx_level,
  output logic rx_new,
  output logic [7:0] rx_new_data
);
  import serial_pkg::*;
  localparam int PW = $clog2(RX_DEPTH);
  if (CLK_HZ / (`OVERSAMPLE * `BAUD_7) < 1 || RX_DEPTH < 2)
    $error("serial_chan: clock too slow or buffer too small");

  function automatic logic [19:0] div_for(input logic [2:0] sel);
    int rate;
    rate = `BAUD_0;
    case (sel)
      3'h1: rate = `BAUD_1;
      3'h2: rate = `BAUD_2;
      3'h3: rate = `BAUD_3;
      3'h4: rate = `BAUD_4;
      3'h5: rate = `BAUD_5;
      3'h6: rate = `BAUD_6;
      3'h7: rate = `BAUD_7;
      default: rate = `BAUD_0;
    endcase
    return 20'(CLK_HZ / (`OVERSAMPLE * rate));
  endfunction

  function automatic logic par_bit(input logic [7:0] d);
    logic ones;
    ones = data8 ? ^d : ^d[6:0];
    case (parity)
      PAR_ODD: return ~ones;
      PAR_EVEN: return ones;
      PAR_ONE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic rxd_s1_q, rxd_s2_q;
  logic [19:0] tick_q, tick_d;
  logic tick;
  rx_state_t rx_state_q, rx_state_d;
  logic [3:0] rx_ph_q, rx_ph_d, rx_n_q, rx_n_d, rx_nbits;
  logic [8:0] rx_sh_q, rx_sh_d, rx_al;
  logic [7:0] rx_byte;
  logic frame_ok, par_ok, push, pop, held_d, new_d;
  logic [7:0] mem [RX_DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [LW-1:0] cnt_q, cnt_d;
  tx_state_t tx_state_q, tx_state_d;
  logic [11:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d, tx_ph_q, tx_ph_d;
  logic txd_d;

  // 16x tick; a rate change lands at the next tick wrap
  assign tick = (tick_q == 20'h0);
  always_comb
  begin
    tick_d = tick ? div_for(baud_sel) - 20'h1 : tick_q - 20'h1;
  end

  // bits per frame from data length and parity
  assign rx_nbits = (data8 ? 4'h8 : 4'h7) + ((parity != PAR_NONE) ? 4'h1 : 4'h0);
  assign rx_al = rx_sh_q >> (4'h9 - rx_nbits);
  assign rx_byte = data8 ? rx_al[7:0] : {1'b0, rx_al[6:0]};
  assign par_ok = (parity == PAR_NONE) || ((data8 ? rx_al[8] : rx_al[7]) == par_bit(rx_byte));

  // deframer: centre-samples each bit, drops bad parity or stop
  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_ph_d = rx_ph_q;
    rx_n_d = rx_n_q;
    rx_sh_d = rx_sh_q;
    frame_ok = 1'b0;
    case (rx_state_q)
      RS_IDLE:
        if (!rxd_s2_q)
        begin
          rx_state_d = RS_START;
          rx_ph_d = 4'h0;
        end
      RS_START:
        if (tick)
        begin
          rx_ph_d = rx_ph_q + 4'h1;
          if (rx_ph_q == 4'h7)
          begin
            rx_state_d = rxd_s2_q ? RS_IDLE : RS_BITS;
            rx_ph_d = 4'h0;
            rx_n_d = 4'h0;
          end
        end
      RS_BITS:
        if (tick)
        begin
          rx_ph_d = rx_ph_q + 4'h1;
          if (rx_ph_q == 4'hf)
          begin
            rx_sh_d = {rxd_s2_q, rx_sh_q[8:1]};
            rx_n_d = rx_n_q + 4'h1;
            if (rx_n_q + 4'h1 == rx_nbits)
              rx_state_d = RS_STOP;
          end
        end
      RS_STOP:
        if (tick)
        begin
          rx_ph_d = rx_ph_q + 4'h1;
          if (rx_ph_q == 4'hf)
          begin
            rx_state_d = RS_IDLE;
            frame_ok = rxd_s2_q && par_ok;
          end
        end
      default: rx_state_d = RS_IDLE;
    endcase
  end

  // receive buffer; a full buffer drops the newcomer
  assign push = frame_ok && (cnt_q != LW'(RX_DEPTH))
    && !(tx_pace && (rx_byte == `CHAR_XON || rx_byte == `CHAR_XOFF));
  assign pop = rx_ready && (cnt_q != '0);
  assign rx_valid = (cnt_q != '0);
  assign rx_data = mem[rd_q];
  assign rx_level = cnt_q;
  always_comb
  begin
    wr_d = push ? ((wr_q == PW'(RX_DEPTH - 1)) ? '0 : wr_q + PW'(1)) : wr_q;
    rd_d = pop ? ((rd_q == PW'(RX_DEPTH - 1)) ? '0 : rd_q + PW'(1)) : rd_q;
    cnt_d = cnt_q + LW'(push) - LW'(pop);
    new_d = push;
    // peer stop/resume characters gate our sender
    held_d = tx_held;
    if (!tx_pace)
      held_d = 1'b0;
    else if (frame_ok && rx_byte == `CHAR_XOFF)
      held_d = 1'b1;
    else if (frame_ok && rx_byte == `CHAR_XON)
      held_d = 1'b0;
  end

  // framer; a character already on the wire finishes even if paused
  assign tx_ready = (tx_state_q == TS_IDLE) && (!tx_held || tx_force);
  always_comb
  begin : tx_next
    logic [11:0] fr;
    logic [3:0] pos;
    fr = 12'hfff;
    pos = data8 ? 4'h9 : 4'h8;
    tx_state_d = tx_state_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_ph_d = tx_ph_q;
    fr[0] = 1'b0;
    if (data8)
      fr[8:1] = tx_data;
    else
      fr[7:1] = tx_data[6:0];
    if (parity != PAR_NONE)
    begin
      fr[pos] = par_bit(tx_data);
      pos = pos + 4'h1;
    end
    case (tx_state_q)
      TS_IDLE:
        if (tx_valid && tx_ready)
        begin
          tx_state_d = TS_SEND;
          tx_sh_d = fr;
          tx_left_d = pos + (stop2 ? 4'h2 : 4'h1);
          tx_ph_d = 4'h0;
        end
      TS_SEND:
        if (tick)
        begin
          tx_ph_d = tx_ph_q + 4'h1;
          if (tx_ph_q == 4'hf)
          begin
            tx_sh_d = {1'b1, tx_sh_q[11:1]};
            tx_left_d = tx_left_q - 4'h1;
            if (tx_left_q == 4'h1)
              tx_state_d = TS_IDLE;
          end
        end
      default: tx_state_d = TS_IDLE;
    endcase
    txd_d = (tx_state_d == TS_SEND) ? tx_sh_d[0] : 1'b1;
  end

  // registers; buffer words need no reset
  always_ff @(posedge sys_clk)
  begin
    rxd_s1_q <= rxd_pin;
    rxd_s2_q <= rxd_s1_q;
    if (push)
      mem[wr_q] <= rx_byte;
    rx_sh_q <= rx_sh_d;
    tx_sh_q <= tx_sh_d;
    rx_new_data <= rx_byte;
    if (rst)
    begin
      tick_q <= 20'h0;
      rx_state_q <= RS_IDLE;
      rx_ph_q <= 4'h0;
      rx_n_q <= 4'h0;
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      tx_held <= 1'b0;
      rx_new <= 1'b0;
      tx_state_q <= TS_IDLE;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
      txd <= 1'b1;
    end
    else
    begin
      tick_q <= tick_d;
      rx_state_q <= rx_state_d;
      rx_ph_q <= rx_ph_d;
      rx_n_q <= rx_n_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      tx_held <= held_d;
      rx_new <= new_d;
      tx_state_q <= tx_state_d;
      tx_left_q <= tx_left_d;
      tx_ph_q <= tx_ph_d;
      txd <= txd_d;
    end
  end

  a_buf_bound: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_q <= LW'(RX_DEPTH)) else $error("buffer level above depth");
  a_pace_hold: assert property (@(posedge sys_clk) disable iff (rst)
    frame_ok && tx_pace && rx_byte == `CHAR_XOFF |=> !tx_ready || tx_force)
    else $error("sender not paused after stop char");
endmodule // serial_chan

// >>> logic/dual_serial_ports.sv
// two independent serial ports with settings, routing and pacing
// assumes the program controller sits on the same sys_clk;
// pwr_on_rst is the power-up reset, rst is preset or soft reset
//
// Notes on behaviour
// - two separate three-wire async ports
// - ports fixed at addresses 9 and 10
// - eight rates from 150 to 19200 baud
// - parity none, odd, even, one, zero
// - stop and resume sending on peer characters
// - receive buffer holds 2000 characters
// - port 9 settings survive preset and reset
// - port 9 input can feed command entry
// - program output echo copies print to 9
// - received characters echoed back when enabled
// - port 10 set only by program
// - print goes to display until redirected
`timescale 1ns/1ps
`include "serial_regs.svh"
module dual_serial_ports #(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int RX_DEPTH = `RX_DEPTH,
  parameter int RX_HI = `RX_DEPTH - `RX_STOP_MARGIN,
  parameter int RX_LO = `RX_DEPTH / 2,
  parameter int LW = $clog2(`RX_DEPTH + 1)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pwr_on_rst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [`CFG_W-1:0] cfg_word,
  input wire logic panel_wr,
  input wire logic [7:0] panel_addr,
  input wire logic [`CFG_W-1:0] panel_word,
  input wire logic cfg9_restore,
  input wire logic [`CFG_W-1:0] cfg9_saved,
  output logic [`CFG_W-1:0] cfg9_word,
  output logic [`CFG_W-1:0] cfg10_word,
  input wire logic dest_wr,
  input wire logic [7:0] dest_addr,
  output logic [7:0] print_dest,
  input wire logic print_valid,
  input wire logic [7:0] print_data,
  output logic print_ready,
  output logic disp_valid,
  output logic [7:0] disp_data,
  input wire logic disp_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic tx9_valid,
  input wire logic [7:0] tx9_data,
  output logic tx9_ready,
  input wire logic tx10_valid,
  input wire logic [7:0] tx10_data,
  output logic tx10_ready,
  output logic rd9_valid,
  output logic [7:0] rd9_data,
  input wire logic rd9_ready,
  output logic rd10_valid,
  output logic [7:0] rd10_data,
  input wire logic rd10_ready,
  input wire logic rxd9_pin,
  output logic txd9_pin,
  input wire logic rxd10_pin,
  output logic txd10_pin
);
  import serial_pkg::*;
  if (RX_LO >= RX_HI || RX_HI > RX_DEPTH || LW < $clog2(RX_DEPTH + 1))
    $error("dual_serial_ports: pacing thresholds do not fit the buffer");

  // ************************************************************
  // settings
  // ************************************************************
  logic [`CFG_W-1:0] cfg9_q, cfg9_d, cfg10_q, cfg10_d;
  logic [7:0] dest_q, dest_d;
  logic rst_any;
  assign rst_any = rst || pwr_on_rst;
  assign cfg9_word = cfg9_q;
  assign cfg10_word = cfg10_q;
  assign print_dest = dest_q;

  // program write beats a panel write in the same cycle
  always_comb
  begin
    cfg9_d = cfg9_q;
    cfg10_d = cfg10_q;
    dest_d = dest_q;
    if (cfg9_restore)
      cfg9_d = cfg9_saved;
    if (panel_wr && panel_addr == `ADDR_PORT_A)
      cfg9_d = panel_word;
    // only the two fixed addresses decode
    if (cfg_wr && cfg_addr == `ADDR_PORT_A)
      cfg9_d = cfg_word;
    else if (cfg_wr && cfg_addr == `ADDR_PORT_B)
      cfg10_d = cfg_word;
    if (dest_wr)
      dest_d = dest_addr;
  end

  // port 9 settings ignore rst; only power-up loads defaults
  always_ff @(posedge sys_clk)
  begin
    if (pwr_on_rst)
      cfg9_q <= `CFG_DEFAULT;
    else
      cfg9_q <= cfg9_d;
    if (rst_any)
    begin
      cfg10_q <= `CFG_DEFAULT;
      dest_q <= `ADDR_DISPLAY;
    end
    else
    begin
      cfg10_q <= cfg10_d;
      dest_q <= dest_d;
    end
  end

  // ************************************************************
  // print routing
  // ************************************************************
  logic to_port, to_disp, slot_free0;
  logic [`CFG_W-1:0] cfg_a [2];
  logic prog_v [2], tx_ready_a [2], rx_v [2], rx_rdy [2];
  logic extra_v [2], rx_new_a [2];
  logic [7:0] prog_d [2], rx_d [2], rx_new_d_a [2];
  logic slot_free [2];
  logic pin_rx [2], pin_tx [2];
  assign cfg_a[0] = cfg9_q;
  assign cfg_a[1] = cfg10_q;
  assign prog_v[0] = tx9_valid;
  assign prog_v[1] = tx10_valid;
  assign prog_d[0] = tx9_data;
  assign prog_d[1] = tx10_data;
  assign pin_rx[0] = rxd9_pin;
  assign pin_rx[1] = rxd10_pin;
  assign txd9_pin = pin_tx[0];
  assign txd10_pin = pin_tx[1];
  assign slot_free0 = slot_free[0];

  // display unless redirected to port 9
  // echo adds port 9 as a second sink
  assign to_disp = (dest_q != `ADDR_PORT_A);
  assign to_port = !to_disp || cfg9_q[`CFG_PROGECHO];
  // both sinks take the character in the same cycle or neither does
  assign disp_valid = print_valid && to_disp && (!to_port || slot_free0);
  assign disp_data = print_data;
  assign extra_v[0] = print_valid && to_port && (!to_disp || disp_ready);
  assign extra_v[1] = 1'b0;
  assign print_ready = (!to_disp || disp_ready) && (!to_port || slot_free0);

  // ************************************************************
  // receive routing
  // ************************************************************
  // port 9 input to command entry when selected
  assign cmd_valid = rx_v[0] && cfg9_q[`CFG_SERIN];
  assign cmd_data = rx_d[0];
  assign rd9_valid = rx_v[0] && !cfg9_q[`CFG_SERIN];
  assign rd9_data = rx_d[0];
  assign rx_rdy[0] = cfg9_q[`CFG_SERIN] ? cmd_ready : rd9_ready;
  assign rd10_valid = rx_v[1];
  assign rd10_data = rx_d[1];
  assign rx_rdy[1] = rd10_ready;

  // ************************************************************
  // per-port logic
  // ************************************************************
  logic prog_take [2];
  assign tx9_ready = prog_take[0];
  assign tx10_ready = prog_take[1];

  for (genvar g = 0; g < 2; g++)
  begin : g_port
    pace_state_t pc_q, pc_d;
    logic echo_q, echo_d, flow_req, tx_v, tx_f, pace_on;
    logic [7:0] echo_data_q, echo_data_d, tx_d;
    logic [LW-1:0] level;

    serial_chan #(
      .CLK_HZ(CLK_HZ),
      .RX_DEPTH(RX_DEPTH),
      .LW(LW)
    ) u_chan (
      .sys_clk(sys_clk),
      .rst(rst_any),
      .baud_sel(cfg_a[g][`CFG_BAUD_LSB +: 3]),
      .parity(parity_t'(cfg_a[g][`CFG_PAR_LSB +: 3])),
      .data8(cfg_a[g][`CFG_DATA8]),
      .stop2(cfg_a[g][`CFG_STOP2]),
      .tx_pace(cfg_a[g][`CFG_TXPACE]),
      .rxd_pin(pin_rx[g]),
      .txd(pin_tx[g]),
      .tx_valid(tx_v),
      .tx_data(tx_d),
      .tx_force(tx_f),
      .tx_ready(tx_ready_a[g]),
      .tx_held(),
      .rx_valid(rx_v[g]),
      .rx_data(rx_d[g]),
      .rx_ready(rx_rdy[g]),
      .rx_level(level),
      .rx_new(rx_new_a[g]),
      .rx_new_data(rx_new_d_a[g])
    );

    assign pace_on = cfg_a[g][`CFG_RXPACE];
    assign flow_req = (pc_q == PC_SEND_OFF) || (pc_q == PC_SEND_ON);

    // sender choice: flow char, then echo, then print, then program
    always_comb
    begin
      tx_f = flow_req;
      tx_v = 1'b1;
      tx_d = prog_d[g];
      if (flow_req)
        tx_d = (pc_q == PC_SEND_OFF) ? `CHAR_XOFF : `CHAR_XON;
      else if (echo_q)
        tx_d = echo_data_q;
      else if (extra_v[g])
        tx_d = print_data;
      else
        tx_v = prog_v[g];
    end
    assign slot_free[g] = tx_ready_a[g] && !flow_req && !echo_q;
    assign prog_take[g] = slot_free[g] && !extra_v[g];

    // hold one received character for echo; a new arrival wins
    always_comb
    begin
      echo_d = echo_q;
      echo_data_d = echo_data_q;
      if (!flow_req && tx_ready_a[g])
        echo_d = 1'b0;
      if (rx_new_a[g] && cfg_a[g][`CFG_RXECHO])
      begin
        echo_d = 1'b1;
        echo_data_d = rx_new_d_a[g];
      end
    end

    always_comb
    begin
      pc_d = pc_q;
      case (pc_q)
        PC_OPEN:
          if (pace_on && level >= LW'(RX_HI))
            pc_d = PC_SEND_OFF;
        PC_SEND_OFF:
          if (!pace_on)
            pc_d = PC_OPEN;
          else if (tx_ready_a[g])
            pc_d = PC_STOPPED;
        PC_STOPPED:
          if (!pace_on)
            pc_d = PC_OPEN;
          else if (level <= LW'(RX_LO))
            pc_d = PC_SEND_ON;
        PC_SEND_ON:
          if (!pace_on || tx_ready_a[g])
            pc_d = PC_OPEN;
        default: pc_d = PC_OPEN;
      endcase
    end

    // per-port state registers
    always_ff @(posedge sys_clk)
    begin
      echo_data_q <= echo_data_d;
      if (rst_any)
      begin
        pc_q <= PC_OPEN;
        echo_q <= 1'b0;
      end
      else
      begin
        pc_q <= pc_d;
        echo_q <= echo_d;
      end
    end

    sequence s_echo_arrive;
      rx_new_a[g] && cfg_a[g][`CFG_RXECHO];
    endsequence
    sequence s_near_full;
      pc_q == PC_OPEN && pace_on && level >= LW'(RX_HI);
    endsequence
    a_echo_held: assert property (@(posedge sys_clk) disable iff (rst_any)
      s_echo_arrive |=> echo_q && echo_data_q == $past(rx_new_d_a[g]))
      else $error("received character not queued for echo");
    a_stop_char: assert property (@(posedge sys_clk) disable iff (rst_any)
      s_near_full ##1 tx_ready_a[g] && pace_on |-> tx_d == `CHAR_XOFF && tx_v)
      else $error("stop character not sent when buffer near full");
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_addr_fixed: assert property (@(posedge sys_clk) disable iff (rst_any)
    cfg_wr && cfg_addr != `ADDR_PORT_A && cfg_addr != `ADDR_PORT_B
    && !panel_wr && !cfg9_restore |=> $stable(cfg9_q) && $stable(cfg10_q))
    else $error("settings changed by a write to an unknown address");
  a_panel_no_b: assert property (@(posedge sys_clk) disable iff (rst_any)
    panel_wr && panel_addr == `ADDR_PORT_B && !cfg_wr |=> $stable(cfg10_q))
    else $error("panel write changed port 10 settings");
  a_cfg9_kept: assert property (@(posedge sys_clk) disable iff (pwr_on_rst)
    rst && !cfg_wr && !panel_wr && !cfg9_restore |=> $stable(cfg9_q))
    else $error("port 9 settings lost on reset");
  a_dest_reset: assert property (@(posedge sys_clk) disable iff (pwr_on_rst)
    rst |=> (dest_q == `ADDR_DISPLAY) [*2] or (dest_q == `ADDR_DISPLAY ##1 $past(dest_wr)))
    else $error("print destination not back on display after reset");
  a_dest_port: assert property (@(posedge sys_clk) disable iff (rst_any)
    dest_q == `ADDR_PORT_A && print_valid && print_ready |-> !disp_valid && extra_v[0])
    else $error("print reached display while redirected");
  a_cmd_route: assert property (@(posedge sys_clk) disable iff (rst_any)
    cfg9_q[`CFG_SERIN] |-> !rd9_valid && (cmd_valid == rx_v[0]))
    else $error("port 9 input not routed to command entry");
  a_prog_echo: assert property (@(posedge sys_clk) disable iff (rst_any)
    disp_valid && disp_ready && cfg9_q[`CFG_PROGECHO] |-> extra_v[0] && slot_free0)
    else $error("printed character not copied to port 9");
endmodule // dual_serial_ports

// >>> verif/serial_peer.sv
// far-side serial peer: byte sender and frame catcher
// assumes the bench sets bit length in sys_clk cycles
`timescale 1ns/1ps
module serial_peer (
  input wire logic sys_clk,
  input wire logic txd,
  input wire logic [15:0] bit_clks,
  input wire logic [3:0] frame_bits,
  output logic rxd
);
  // ****************
  // peer behaviour
  // ****************
  logic [11:0] got [$];
  logic [11:0] v;
  initial rxd = 1'b1;
  // sample at bit centres; bits after start, stops included
  always
  begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge sys_clk);
    v = 12'hfff;
    for (int i = 0; i < frame_bits; i++)
    begin
      repeat (bit_clks) @(posedge sys_clk);
      v[i] = txd;
    end
    got.push_back(v);
  end
  // plain 8n1 sender, no local echo
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      rxd <= f[i]; // line rests high after the stop bit
      repeat (bit_clks - 1) @(posedge sys_clk);
    end
  endtask
endmodule // serial_peer

// >>> verif/tb_dual_serial_ports.sv
// bench for the dual serial port block with a peer on each line
// assumes a short clock figure so 9600 baud is 128 clocks a bit
`timescale 1ns/1ps
module tb_dual_serial_ports;
  // ****************
  // harness
  // ****************
  logic sys_clk = 0, rst = 1, pwr_on_rst = 1, cfg_wr = 0, panel_wr = 0, cfg9_restore = 0;
  logic [7:0] cfg_addr = 0, panel_addr = 0, dest_addr = 0, print_data = 0, tx9_data = 0;
  logic [12:0] cfg_word = 0, panel_word = 0, cfg9_saved = 0, cfg9_word, cfg10_word;
  logic dest_wr = 0, print_valid = 0, disp_ready = 1, cmd_ready = 0, tx9_valid = 0;
  logic tx10_valid = 0, rd9_ready = 0, rd10_ready = 0, rxd9, rxd10, txd9, txd10;
  logic [7:0] tx10_data = 0, print_dest, disp_data, cmd_data, rd9_data, rd10_data;
  logic print_ready, disp_valid, cmd_valid, tx9_ready, tx10_ready, rd9_valid, rd10_valid;
  logic [15:0] bc = 16'h0080;
  logic [3:0] fb10 = 4'ha;
  int mismatches = 0, cmp_count = 0;
  logic [11:0] f;
  always #2 sys_clk = ~sys_clk;
  dual_serial_ports #(.CLK_HZ(1228800), .RX_DEPTH(16), .RX_HI(12), .RX_LO(4)) dut (
    .sys_clk(sys_clk), .rst(rst), .pwr_on_rst(pwr_on_rst), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_word(cfg_word), .panel_wr(panel_wr), .panel_addr(panel_addr),
    .panel_word(panel_word), .cfg9_restore(cfg9_restore), .cfg9_saved(cfg9_saved),
    .cfg9_word(cfg9_word), .cfg10_word(cfg10_word), .dest_wr(dest_wr), .dest_addr(dest_addr),
    .print_dest(print_dest), .print_valid(print_valid), .print_data(print_data),
    .print_ready(print_ready), .disp_valid(disp_valid), .disp_data(disp_data),
    .disp_ready(disp_ready), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .tx9_valid(tx9_valid), .tx9_data(tx9_data), .tx9_ready(tx9_ready), .tx10_valid(tx10_valid),
    .tx10_data(tx10_data), .tx10_ready(tx10_ready), .rd9_valid(rd9_valid), .rd9_data(rd9_data),
    .rd9_ready(rd9_ready), .rd10_valid(rd10_valid), .rd10_data(rd10_data),
    .rd10_ready(rd10_ready), .rxd9_pin(rxd9), .txd9_pin(txd9), .rxd10_pin(rxd10),
    .txd10_pin(txd10));
  serial_peer p9 (.sys_clk(sys_clk), .txd(txd9), .bit_clks(bc), .frame_bits(fb10), .rxd(rxd9));
  serial_peer p10 (.sys_clk(sys_clk), .txd(txd10), .bit_clks(bc), .frame_bits(fb10), .rxd(rxd10));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = rd10_valid;
      1: sig = cmd_valid;
      2: sig = tx10_ready;
      4: sig = rd9_valid;
      default: sig = print_ready;
    endcase
  endfunction
  // bounded wait at falling edges; the next rising edge takes
  task automatic waitn(input int s);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (sig(s) !== 1'b1 && n < 40000);
    if (n >= 40000)
    begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic getf(input bit b10, output logic [11:0] g);
    int n;
    n = 0;
    while ((b10 ? p10.got.size() : p9.got.size()) == 0 && n < 40000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 40000)
    begin
      mismatches++;
      conclude();
    end
    g = b10 ? p10.got.pop_front() : p9.got.pop_front();
  endtask
  // expected bits after start: data lsb first, parity, stops high
  function automatic logic [11:0] fexp(input logic [7:0] d, input logic [12:0] w);
    logic [11:0] r;
    int n;
    n = w[6] ? 8 : 7;
    r = 12'hfff;
    for (int i = 0; i < n; i++)
      r[i] = d[i];
    case (w[5:3])
      3'h1: r[n] = w[6] ? ~^d : ~^d[6:0];
      3'h2: r[n] = w[6] ? ^d : ^d[6:0];
      3'h4: r[n] = 1'b0;
      default: r[n] = 1'b1;
    endcase
    return r;
  endfunction
  task automatic cfgw(input logic [7:0] a, input logic [12:0] w);
    @(posedge sys_clk);
    cfg_wr <= 1;
    cfg_addr <= a;
    cfg_word <= w;
    @(posedge sys_clk);
    cfg_wr <= 0;
    @(negedge sys_clk);
  endtask
  task automatic tx_put(input logic [7:0] b);
    @(posedge sys_clk);
    tx10_valid <= 1;
    tx10_data <= b;
    waitn(2);
    @(posedge sys_clk);
    tx10_valid <= 0;
  endtask
  task automatic prt(input logic [7:0] b, input logic dv);
    @(posedge sys_clk);
    print_valid <= 1;
    print_data <= b;
    disp_ready <= dv;
    waitn(3);
    chk(16'(disp_valid), 16'(dv));
    chk(16'(disp_data), 16'(b));
    @(posedge sys_clk);
    print_valid <= 0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_settings();
    chk(16'(print_dest), 16'h0001);
    chk(16'(cfg9_word), 16'h1b46);
    cfgw(8'h0a, 13'h0047);
    chk(16'(cfg10_word), 16'h0047);
    @(posedge sys_clk);
    panel_wr <= 1;
    panel_addr <= 8'h0a;
    panel_word <= 13'h0011;
    @(posedge sys_clk);
    panel_addr <= 8'h09;
    @(posedge sys_clk);
    panel_wr <= 0;
    @(negedge sys_clk);
    chk(16'(cfg10_word), 16'h0047);
    chk(16'(cfg9_word), 16'h0011);
    cfgw(8'h08, 13'h0005);
    chk(16'(cfg9_word), 16'h0011);
    @(posedge sys_clk);
    rst <= 1;
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    @(negedge sys_clk);
    chk(16'(cfg9_word), 16'h0011);
    @(posedge sys_clk);
    cfg9_restore <= 1;
    cfg9_saved <= 13'h1046;
    @(posedge sys_clk);
    cfg9_restore <= 0;
    @(negedge sys_clk);
    chk(16'(cfg9_word), 16'h1046);
  endtask
  // every parity mode, both lengths, two rates on port 10
  task automatic s_frames();
    logic [12:0] w;
    for (int p = 0; p < 5; p++)
    begin
      w = {5'h00, p[0], p != 1, 3'(p), p[1] ? 3'h7 : 3'h6};
      cfgw(8'h0a, w);
      bc = p[1] ? 16'h0040 : 16'h0080;
      fb10 = 4'(w[6] + 8 + (p != 0) + w[7]);
      tx_put(8'hc3 ^ 8'(p));
      getf(1, f);
      chk(16'(f), 16'(fexp(8'hc3 ^ 8'(p), w)));
    end
    bc = 16'h0080;
    fb10 = 4'ha;
  endtask
  task automatic s_rx();
    cfgw(8'h0a, 13'h0046);
    p10.send(8'ha5);
    waitn(0);
    chk(16'(rd10_data), 16'h00a5);
    rd10_ready <= 1;
    @(posedge sys_clk);
    rd10_ready <= 0;
    p9.send(8'hc6);
    waitn(4);
    chk(16'(rd9_data), 16'h00c6);
    rd9_ready <= 1;
    @(posedge sys_clk);
    rd9_ready <= 0;
    cfgw(8'h09, 13'h1b46);
    p9.send(8'h3c);
    waitn(1);
    chk(16'(cmd_data), 16'h003c);
    cmd_ready <= 1;
    @(posedge sys_clk);
    cmd_ready <= 0;
  endtask
  task automatic s_print();
    prt(8'h4e, 1'b1);
    getf(0, f);
    chk(16'(f), 16'(fexp(8'h4e, 13'h0046)));
    @(posedge sys_clk);
    dest_wr <= 1;
    dest_addr <= 8'h09;
    @(posedge sys_clk);
    dest_wr <= 0;
    @(negedge sys_clk);
    chk(16'(print_dest), 16'h0009);
    prt(8'h72, 1'b0);
    getf(0, f);
    chk(16'(f), 16'(fexp(8'h72, 13'h0046)));
  endtask
  // peer pause holds the sender off until resume
  task automatic s_pace();
    int seen;
    cfgw(8'h0a, 13'h0246);
    p10.send(8'h13);
    repeat (8) @(posedge sys_clk);
    seen = 0;
    repeat (1000)
    begin
      @(negedge sys_clk);
      seen += (tx10_ready !== 1'b0);
    end
    chk(16'(seen), 16'h0000);
    p10.send(8'h11);
    tx_put(8'h5a);
    getf(1, f);
    chk(16'(f), 16'(fexp(8'h5a, 13'h0046)));
  endtask
  task automatic s_echo();
    cfgw(8'h0a, 13'h0446);
    p10.send(8'h69);
    getf(1, f);
    chk(16'(f), 16'(fexp(8'h69, 13'h0046)));
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    pwr_on_rst <= 0;
    @(negedge sys_clk);
    chk(16'({txd9, txd10}), 16'h0003);
    s_settings();
    s_frames();
    s_rx();
    s_print();
    s_pace();
    s_echo();
    conclude();
  end
endmodule // tb_dual_serial_ports
